// ### rlo_ctrl_model.sv
// controller model: sends update and diagnostic messages to the latch
// assumes the latch's core clock; the bench calls the tasks below
`timescale 1ns/1ps
module rlo_ctrl_model
  import rlo_pkg::*;
(
  input  wire logic core_clk,  // core clock
  output rlo_msg_t  msg        // message to the latch
);
  // ****************************************
  // message driver
  // ****************************************
  initial msg = '{valid: 1'b0, kind: RLO_MSG_UPDATE, image: 8'h00};

  // one message a call; idle image is inverted so stale data never passes
  task automatic send(input rlo_msg_kind_t kind, input logic [7:0] image);
    @(posedge core_clk);
    msg <= '{valid: 1'b1, kind: kind, image: image};
    @(posedge core_clk);
    msg <= '{valid: 1'b0, kind: kind, image: ~image};
  endtask : send

  // periodic refresh of the whole image, messages gap + 2 cycles apart
  task automatic refresh(input logic [7:0] image, input int unsigned n, input int unsigned gap);
    repeat (n)
    begin
      send(RLO_MSG_UPDATE, image);
      repeat (gap) @(posedge core_clk);
    end
  endtask : refresh
endmodule : rlo_ctrl_model

// ### rlo_latch.sv
// eight-channel relay output latch with scan sequencer, watchdog power cut
// and nmi strap latch
// assumes messages come from same-clock logic; watchdog and strap are pins
`timescale 1ns/1ps
module rlo_latch
  import rlo_pkg::*;
#(
  parameter int unsigned SCAN_CYC = SCAN_CYCLES
)
(
  input  wire logic       core_clk,       // 20 MHz core clock
  input  wire logic       reset_n,        // sync reset, active low
  input  wire rlo_msg_t   ctrl_msg,       // message from controller logic
  input  wire logic       wdog_rst_pin,   // watchdog in reset, high
  input  wire logic       nmi_strap_pin,  // strap fitted, high
  output logic [7:0]      chan_drive_n,   // relay drive lines, low = on
  output logic [7:0]      chan_led,       // channel indicators, high = lit
  output logic            relay_pwr_en,   // relay operating power switch
  output logic            nmi_out,        // non-maskable interrupt line
  output logic            diag_req        // pulse to common diag handler
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (SCAN_CYC < 4 || SCAN_CYC > 65536)
  begin : g_bad_scan
    $error("rlo_latch: SCAN_CYC out of range");
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] pin_sync;
  logic       wdog_s;
  logic       strap_s;

  // both chains reset to one: watchdog reads as in reset and strap as fitted,
  // so power stays off and no false nmi shows until the pins are really seen
  rlo_sync2 #(.WIDTH(2)) rlo_sync2_i
  (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in ({nmi_strap_pin, wdog_rst_pin}),
    .sync_out (pin_sync)
  );
  assign wdog_s  = pin_sync[0];
  assign strap_s = pin_sync[1];

  // ****************************************
  // scan rate divider
  // ****************************************
  logic [15:0] div_q;
  logic [15:0] div_d;
  logic        scan_tick;

  // one-cycle enable every SCAN_CYC cycles
  always_comb
  begin
    scan_tick = (div_q == 16'((SCAN_CYC - 1) & 32'hffff));
    div_d     = scan_tick ? 16'h0000 : div_q + 16'h0001;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      div_q <= 16'h0000;
    else
      div_q <= div_d;
  end

  // ****************************************
  // message decode
  // ****************************************
  logic upd_hit;
  logic diag_hit;

  assign upd_hit  = ctrl_msg.valid && (ctrl_msg.kind == RLO_MSG_UPDATE);
  assign diag_hit = ctrl_msg.valid && (ctrl_msg.kind == RLO_MSG_DIAG);

  // ****************************************
  // image store, scan sequencer and latch
  // ****************************************
  rlo_scan_state_t state_q;
  rlo_scan_state_t state_d;
  logic [7:0]      image_q;
  logic [7:0]      image_d;
  logic [7:0]      drive_n_q;
  logic [7:0]      drive_n_d;
  logic [7:0]      led_q;
  logic [7:0]      led_d;
  logic            diag_q;
  logic            diag_d;

  // an update in a scan copy cycle wins, so the newest image is never lost
  always_comb
  begin
    state_d   = state_q;
    image_d   = image_q;
    drive_n_d = drive_n_q;
    diag_d    = diag_hit;
    case (state_q)
      RLO_SC_IDLE:
      begin
        if (scan_tick)
          state_d = RLO_SC_OUT;
      end
      RLO_SC_OUT:
      begin
        drive_n_d = ~image_q;
        state_d   = RLO_SC_IN;
      end
      RLO_SC_IN:
      begin
        // no inputs on this board, step kept for scan structure
        state_d = RLO_SC_IDLE;
      end
      default:
      begin
        state_d = RLO_SC_IDLE;
      end
    endcase
    if (upd_hit)
    begin
      image_d   = ctrl_msg.image;
      drive_n_d = ~ctrl_msg.image;
    end
    led_d = ~drive_n_d;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      state_q   <= RLO_SC_IDLE;
      image_q   <= IMAGE_RESET;
      drive_n_q <= DRIVE_RESET_N;
      led_q     <= ~DRIVE_RESET_N;
      diag_q    <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      image_q   <= image_d;
      drive_n_q <= drive_n_d;
      led_q     <= led_d;
      diag_q    <= diag_d;
    end
  end

  // ****************************************
  // relay power and nmi latch
  // ****************************************
  logic pwr_q;
  logic pwr_d;
  logic nmi_q;
  logic nmi_d;

  // one shared switch drops every relay in the same cycle
  always_comb
  begin
    pwr_d = ~wdog_s;
    nmi_d = ~strap_s;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      pwr_q <= 1'b0;
      nmi_q <= 1'b0;
    end
    else
    begin
      pwr_q <= pwr_d;
      nmi_q <= nmi_d;
    end
  end

  assign chan_drive_n = drive_n_q;
  assign chan_led     = led_q;
  assign relay_pwr_en = pwr_q;
  assign nmi_out      = nmi_q;
  assign diag_req     = diag_q;

  // ****************************************
  // assertions
  // ****************************************
  sequence s_update;
    ctrl_msg.valid && (ctrl_msg.kind == RLO_MSG_UPDATE);
  endsequence

  sequence s_copy_step;
    (state_q == RLO_SC_OUT) && !upd_hit;
  endsequence

  // pin levels held long enough to pass both sync stages and the register;
  // the reset term keeps an attempt that starts on the release edge out
  sequence s_wdog_held;
    (reset_n && wdog_rst_pin) [*3];
  endsequence

  sequence s_wdog_clear;
    (reset_n && !wdog_rst_pin) [*3];
  endsequence

  sequence s_strap_held;
    (reset_n && nmi_strap_pin) [*3];
  endsequence

  sequence s_strap_open;
    (reset_n && !nmi_strap_pin) [*3];
  endsequence

  property p_update_latch;
    @(posedge core_clk) disable iff (!reset_n)
    s_update |=> (chan_drive_n == ~$past(ctrl_msg.image)) && (image_q == $past(ctrl_msg.image));
  endproperty
  a_update_latch: assert property (p_update_latch) else $error("update not latched");

  property p_bit_order;
    @(posedge core_clk) disable iff (!reset_n)
    s_update |=> (chan_drive_n[0] == !$past(ctrl_msg.image[0]))
                 && (chan_drive_n[7] == !$past(ctrl_msg.image[7]));
  endproperty
  a_bit_order: assert property (p_bit_order) else $error("channel bit order wrong");

  property p_scan_copy;
    @(posedge core_clk) disable iff (!reset_n)
    (scan_tick && state_q == RLO_SC_IDLE) ##1 s_copy_step |=> (chan_drive_n == ~$past(image_q));
  endproperty
  a_scan_copy: assert property (p_scan_copy) else $error("scan copy missed");

  property p_scan_sequence;
    @(posedge core_clk) disable iff (!reset_n)
    (scan_tick && state_q == RLO_SC_IDLE) |=> (state_q == RLO_SC_OUT) ##1 (state_q == RLO_SC_IN)
                                             ##1 (state_q == RLO_SC_IDLE);
  endproperty
  a_scan_sequence: assert property (p_scan_sequence) else $error("scan order");

  property p_input_noop;
    @(posedge core_clk) disable iff (!reset_n)
    (state_q == RLO_SC_IN) && !upd_hit |=> $stable(chan_drive_n) && $stable(image_q);
  endproperty
  a_input_noop: assert property (p_input_noop) else $error("input scan wrote");

  property p_latch_hold;
    @(posedge core_clk) disable iff (!reset_n)
    !upd_hit && (state_q != RLO_SC_OUT) |=> $stable(chan_drive_n);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch moved");

  property p_led_match;
    @(posedge core_clk) disable iff (!reset_n)
    ##1 (chan_led == ~chan_drive_n);
  endproperty
  a_led_match: assert property (p_led_match) else $error("indicator mismatch");

  property p_wdog_cut;
    @(posedge core_clk) disable iff (!reset_n)
    s_wdog_held |=> !relay_pwr_en;
  endproperty
  a_wdog_cut: assert property (p_wdog_cut) else $error("relay power not cut");

  property p_wdog_clear;
    @(posedge core_clk) disable iff (!reset_n)
    s_wdog_clear |=> relay_pwr_en;
  endproperty
  a_wdog_clear: assert property (p_wdog_clear) else $error("relay power not back");

  property p_diag_keep;
    @(posedge core_clk) disable iff (!reset_n)
    diag_hit && (state_q != RLO_SC_OUT) |=> diag_req && $stable(chan_drive_n);
  endproperty
  a_diag_keep: assert property (p_diag_keep) else $error("diag touched latch");

  property p_diag_only;
    @(posedge core_clk) disable iff (!reset_n)
    !diag_hit |=> !diag_req;
  endproperty
  a_diag_only: assert property (p_diag_only) else $error("stray diag pulse");

  property p_nmi_strap;
    @(posedge core_clk) disable iff (!reset_n)
    s_strap_held |=> !nmi_out;
  endproperty
  a_nmi_strap: assert property (p_nmi_strap) else $error("nmi not suppressed");

  property p_nmi_open;
    @(posedge core_clk) disable iff (!reset_n)
    s_strap_open |=> nmi_out;
  endproperty
  a_nmi_open: assert property (p_nmi_open) else $error("nmi not raised");

  property p_reset_off;
    @(posedge core_clk)
    !reset_n |=> (chan_drive_n == DRIVE_RESET_N) && (chan_led == ~DRIVE_RESET_N)
                 && !relay_pwr_en && !nmi_out && !diag_req;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("not off after reset");

endmodule : rlo_latch

// ### rlo_latch_bench.sv
// self-checking bench for the relay output latch
// assumes a 20 MHz clock and a short scan period for speed
`timescale 1ns/1ps
module rlo_latch_bench
  import rlo_pkg::*;
;
  localparam int unsigned SCAN = 4;  // short scan keeps the run brief
  logic       core_clk;
  logic       reset_n;
  rlo_msg_t   ctrl_msg;
  logic       wdog_rst_pin;
  logic       nmi_strap_pin;
  logic [7:0] chan_drive_n;
  logic [7:0] chan_led;
  logic       relay_pwr_en;
  logic       nmi_out;
  logic       diag_req;
  int         error_cnt  = 0;
  int         num_checks = 0;

  // ****************************************
  // design and controller model
  // ****************************************
  rlo_latch #(.SCAN_CYC(SCAN)) rlo_latch_i (
    .core_clk(core_clk), .reset_n(reset_n), .ctrl_msg(ctrl_msg),
    .wdog_rst_pin(wdog_rst_pin), .nmi_strap_pin(nmi_strap_pin),
    .chan_drive_n(chan_drive_n), .chan_led(chan_led),
    .relay_pwr_en(relay_pwr_en), .nmi_out(nmi_out), .diag_req(diag_req));
  rlo_ctrl_model rlo_ctrl_model_i (.core_clk(core_clk), .msg(ctrl_msg));

  // clock, 50 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ****************************************
  // compare and closing tasks
  // ****************************************
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp, input string what);
    chk8({7'h00, got}, {7'h00, exp}, what);
  endtask : chk1

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  // pins pass two sync stages and a register
  task automatic settle3;
    repeat (3) @(posedge core_clk);
    #1;
  endtask : settle3

  // ****************************************
  // scenarios
  // ****************************************
  // one channel at a time catches swapped or shifted bits
  task automatic t_walk;
    for (int i = 0; i < 8; i++)
    begin
      rlo_ctrl_model_i.send(RLO_MSG_UPDATE, 8'h01 << i);
      #1;
      chk8(chan_drive_n, ~(8'h01 << i), "drive");
      chk8(chan_led, 8'h01 << i, "led");
    end
  endtask : t_walk

  // diag must pulse once and leave the latch alone
  task automatic t_diag;
    rlo_ctrl_model_i.send(RLO_MSG_DIAG, 8'h5a);
    #1;
    chk1(diag_req, 1'b1, "diag pulse");
    chk8(chan_drive_n, 8'h7f, "drive after diag");
    @(posedge core_clk);
    #1;
    chk1(diag_req, 1'b0, "diag end");
  endtask : t_diag

  // several scan copies pass between periodic refreshes
  task automatic t_scan;
    rlo_ctrl_model_i.refresh(8'hc3, 3, 3 * SCAN);
    #1;
    chk8(chan_drive_n, 8'h3c, "drive after scans");
    chk8(chan_led, 8'hc3, "led after scans");
  endtask : t_scan

  // watchdog reset cuts relay power but keeps the latch contents
  task automatic t_wdog;
    chk1(relay_pwr_en, 1'b1, "power on");
    @(posedge core_clk);
    wdog_rst_pin <= 1'b1;
    settle3();
    chk1(relay_pwr_en, 1'b0, "power cut");
    chk8(chan_drive_n, 8'h3c, "latch kept");
    @(posedge core_clk);
    wdog_rst_pin <= 1'b0;
    settle3();
    chk1(relay_pwr_en, 1'b1, "power back");
  endtask : t_wdog

  // strap fitted holds the nmi off, strap absent raises it
  task automatic t_nmi;
    chk1(nmi_out, 1'b1, "nmi strap absent");
    @(posedge core_clk);
    nmi_strap_pin <= 1'b1;
    settle3();
    chk1(nmi_out, 1'b0, "nmi strap fitted");
    @(posedge core_clk);
    nmi_strap_pin <= 1'b0;
    settle3();
    chk1(nmi_out, 1'b1, "nmi strap removed");
  endtask : t_nmi

  // mid-run reset drops every output to its safe state, then updates work again
  task automatic t_reset;
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk8(chan_drive_n, DRIVE_RESET_N, "drive in reset");
    chk8(chan_led, ~DRIVE_RESET_N, "led in reset");
    chk1(relay_pwr_en, 1'b0, "power in reset");
    chk1(nmi_out, 1'b0, "nmi in reset");
    @(posedge core_clk);
    reset_n <= 1'b1;
    settle3();
    chk8(chan_drive_n, DRIVE_RESET_N, "drive after reset");
    chk1(relay_pwr_en, 1'b1, "power after reset");
    chk1(nmi_out, 1'b1, "nmi after reset");
    rlo_ctrl_model_i.send(RLO_MSG_UPDATE, 8'h81);
    #1;
    chk8(chan_drive_n, 8'h7e, "drive after first update");
  endtask : t_reset

  // main sequence
  initial
  begin
    reset_n       = 1'b0;
    wdog_rst_pin  = 1'b0;
    nmi_strap_pin = 1'b0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    #1;
    chk8(chan_drive_n, 8'hff, "drive at reset");
    chk8(chan_led, 8'h00, "led at reset");
    t_walk();
    t_diag();
    t_scan();
    t_wdog();
    t_nmi();
    t_reset();
    wrap_up();
  end

  // watchdog: the run needs well under 2000 cycles
  initial
  begin
    #100us;
    error_cnt++;
    wrap_up();
  end
endmodule : rlo_latch_bench

// ### rlo_pkg.sv
// package of constants and carrier types for the relay output latch
// assumes one 20 MHz core clock and synchronous active-low reset
package rlo_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned SCAN_PERIOD_US  = 10;
  localparam int unsigned SCAN_CYCLES     = (SCAN_PERIOD_US * (CLK_HZ / 1_000_000));

  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int unsigned CHAN_COUNT      = 8;
  localparam logic [7:0]  IMAGE_RESET     = 8'h00;  // every channel off
  localparam logic [7:0]  DRIVE_RESET_N   = 8'hff;  // every drive line high
  localparam int unsigned SYNC_STAGES     = 2;

  // ****************************************
  // message kinds of the controller protocol
  // ****************************************
  typedef enum logic [0:0]
  {
    RLO_MSG_UPDATE = 1'b0,
    RLO_MSG_DIAG   = 1'b1
  } rlo_msg_kind_t;

  // one update or diagnostic message from the controller
  typedef struct packed
  {
    logic          valid;
    rlo_msg_kind_t kind;
    logic [7:0]    image;   // bit 0 is channel 1, bit 7 is channel 8
  } rlo_msg_t;

  // scan sequencer states
  typedef enum logic [1:0]
  {
    RLO_SC_IDLE = 2'b00,
    RLO_SC_OUT  = 2'b01,
    RLO_SC_IN   = 2'b10
  } rlo_scan_state_t;

endpackage : rlo_pkg

// ### rlo_sync2.sv
// two-stage synchroniser for pin-level inputs, one chain per bit
// assumes inputs are asynchronous levels; reset value is a constant
`timescale 1ns/1ps
module rlo_sync2
  import rlo_pkg::*;
#(
  parameter int unsigned WIDTH = 2
)
(
  input  wire logic             core_clk,  // core clock
  input  wire logic             reset_n,   // sync reset, active low
  input  wire logic [WIDTH-1:0] async_in,  // raw pin levels
  output logic      [WIDTH-1:0] sync_out   // synchronised levels
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (WIDTH < 1)
  begin : g_bad_width
    $error("rlo_sync2: WIDTH must be at least one");
  end

  // ****************************************
  // per-bit chains
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      logic meta_q;
      logic stab_q;
      // first stage feeds only the second stage
      always_ff @(posedge core_clk)
      begin
        if (!reset_n)
        begin
          meta_q <= 1'b1;  // one is the safe reading of every pin here
          stab_q <= 1'b1;
        end
        else
        begin
          meta_q <= async_in[gi];
          stab_q <= meta_q;
        end
      end
      assign sync_out[gi] = stab_q;
    end
  endgenerate

endmodule : rlo_sync2
